// *** fcs_unit.sv ***
// Real-number reciprocal, scale, convert, translate, negate, magnitude, min/max unit.
// Assumes an APB master on clk; all inputs are synchronous to clk.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Reciprocal gives 1.0 over operand, may flag.
// - Scale multiplies real left by two-power right.
// - Reverse scale swaps real and integer sources.
// - Exponent step never flags; final product may.
// - Scale real at modifier precision, power singleword.
// - Scalar fix rounding chosen by first modifier.
// - Vector fix always uses status rounding field.
// - Fix result width by modifier; integer overflow flagged.
// - Float overflows only halfword real from wide ints.
// - Float target and source precision by modifiers.
// - Equal-precision translate not wrapping past word 15 never clobbers unread source.
// - Non-narrowing translate flags only exceptional sources.
// - Translate narrowing rounds by status rounding field.
// - Negate propagates exceptional values and flags them.
// - Magnitude honours exceptional values and flags them.
// - Minimum picks smaller, propagates exceptions, flags.
// - Maximum picks larger, same exception behaviour.
// - Vector min/max writes first vector or pointer.
// - Rounding read and write move field via operand.
// - Field codes: floor zero, ceiling four.
// - Invalid wins; otherwise fixed seven-class ordering.
// - Unary exceptional values follow fixed propagation table.
// - Real flags sticky until status register write.
module fcs_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import fcs_pkg::*;

  function automatic logic isMemAddr(input logic [ADDR_W-1:0] a);
    return (a & MEM_MASK) == OFF_MEM;
  endfunction

  function automatic logic rndUp(input logic [2:0] m, input logic neg, input logic lsb,
                                 input logic half, input logic sticky);
    case (m)
      RND_FLOOR: rndUp = neg & (half | sticky);
      RND_CEIL: rndUp = !neg & (half | sticky);
      // Ties go toward plus infinity, so a negative tie keeps its magnitude.
      RND_HALFUP: rndUp = neg ? (half & sticky) : half;
      RND_STABLE: rndUp = half & (sticky | lsb);
      default: rndUp = 1'b0;
    endcase
  endfunction

  function automatic fcs_real_t unpack(input logic [31:0] w, input logic [1:0] p);
    fcs_real_t u;
    logic [7:0] be;
    logic [22:0] fr;
    logic ones;
    if (p == PREC_H) begin
      u.sign = w[15];
      be = {3'h0, w[14:10]};
      fr = {w[9:0], 13'h0};
      ones = w[14:10] == H_EXP_ONES;
      u.exp = $signed({26'h0, be}) - H_BIAS;
    end else begin
      u.sign = w[31];
      be = w[30:23];
      fr = w[22:0];
      ones = be == S_EXP_ONES;
      u.exp = $signed({26'h0, be}) - S_BIAS;
    end
    u.man = {1'b1, fr};
    if (ones) u.cls = (fr == '0) ? CLS_OVF : CLS_NAN;
    else if (be == '0) u.cls = (fr == '0) ? CLS_ZERO : CLS_UNF;
    else u.cls = CLS_ORD;
    return u;
  endfunction

  function automatic fcs_res_t excRes(input fcs_cls_t c, input logic s, input logic [1:0] p);
    fcs_res_t r;
    logic h;
    h = p == PREC_H;
    r.flags = '0;
    r.flags[FL_ROVF] = c == CLS_OVF;
    r.flags[FL_RUNF] = c == CLS_UNF;
    r.flags[FL_NAN] = c == CLS_NAN;
    case (c)
      CLS_OVF: r.word = h ? {16'h0, s, H_EXP_ONES, 10'h0} : {s, S_EXP_ONES, 23'h0};
      CLS_NAN: r.word = h ? {16'h0, 1'b0, H_EXP_ONES, 10'h1} : S_NAN;
      CLS_UNF: r.word = h ? {16'h0, s, 5'h0, 10'h1} : {s, 8'h0, 23'h1};
      default: r.word = '0;
    endcase
    return r;
  endfunction

  function automatic fcs_res_t pack(input logic s, input logic signed [33:0] e,
                                    input logic [23:0] m, input logic [1:0] p,
                                    input logic [2:0] mode);
    logic [11:0] hm;
    logic signed [33:0] ee;
    logic signed [33:0] be;
    logic h;
    fcs_res_t r;
    h = p == PREC_H;
    ee = e;
    hm = {1'b0, m[23:13]} + {11'h0, rndUp(mode, s, m[13], m[12], |m[11:0])};
    if (h && hm[11]) begin
      ee = e + 34'sh1;
      hm = hm >> 1;
    end
    be = ee + (h ? H_BIAS : S_BIAS);
    if (be > (h ? H_BE_MAX : S_BE_MAX)) r = excRes(CLS_OVF, s, p);
    else if (be < 34'sh1) r = excRes(CLS_UNF, s, p);
    else begin
      r.flags = '0;
      r.word = h ? {16'h0, s, be[4:0], hm[9:0]} : {s, be[7:0], m[22:0]};
    end
    return r;
  endfunction

  function automatic logic [2:0] rankOf(input fcs_real_t u);
    case (u.cls)
      CLS_OVF: rankOf = u.sign ? 3'h0 : 3'h6;
      CLS_ORD: rankOf = u.sign ? 3'h1 : 3'h5;
      CLS_UNF: rankOf = u.sign ? 3'h2 : 3'h4;
      default: rankOf = 3'h3;
    endcase
  endfunction

  function automatic logic isLess(input fcs_real_t x, input fcs_real_t y);
    logic [2:0] rx;
    logic [2:0] ry;
    logic magLt;
    logic magGt;
    rx = rankOf(x);
    ry = rankOf(y);
    magLt = (x.exp < y.exp) || (x.exp == y.exp && x.man < y.man);
    magGt = (x.exp > y.exp) || (x.exp == y.exp && x.man > y.man);
    return (rx < ry) || (rx == ry && ((rx == 3'h5 && magLt) || (rx == 3'h1 && magGt)));
  endfunction

  function automatic logic signed [32:0] intOf(input logic [31:0] w, input logic [1:0] p);
    case (p)
      PREC_Q: intOf = 33'(signed'(w[7:0]));
      PREC_H: intOf = 33'(signed'(w[15:0]));
      default: intOf = 33'(signed'(w));
    endcase
  endfunction

  function automatic fcs_res_t execOp(input fcs_ctrl_t c, input logic [31:0] a,
                                      input logic [31:0] b, input logic [2:0] field,
                                      input logic inVec);
    fcs_res_t r;
    fcs_real_t x;
    fcs_real_t y;
    logic [2:0] mode;
    logic [63:0] t;
    logic [32:0] mag;
    logic [32:0] lim;
    logic [31:0] sh;
    logic [47:0] q;
    logic [4:0] lead;
    logic signed [32:0] iv;
    logic pickA;
    r = '0;
    mode = (inVec || c.rnd == RND_CONFIG) ? field : c.rnd;
    x = unpack((c.op == OP_SCALE || c.op == OP_MIN || c.op == OP_MAX) ? a : b,
               (c.op == OP_FIX || c.op == OP_TRANS) ? c.precSrc : c.precDst);
    y = unpack(b, c.precDst);
    case (c.op)
      OP_RECIP: begin
        if (x.cls == CLS_ORD) begin
          q = RECIP_NUM / {24'h0, x.man};
          if (q[24]) r = pack(x.sign, -x.exp, 24'h800000, c.precDst, field);
          else r = pack(x.sign, -x.exp - 34'sh1, q[23:0], c.precDst, field);
        end else if (x.cls == CLS_ZERO) r = excRes(CLS_NAN, 1'b0, c.precDst);
        else if (x.cls == CLS_OVF) r = excRes(CLS_UNF, x.sign, c.precDst);
        else if (x.cls == CLS_UNF) r = excRes(CLS_OVF, x.sign, c.precDst);
        else r = excRes(CLS_NAN, 1'b0, c.precDst);
      end
      OP_SCALE, OP_RSCALE: begin
        // The exponent sum is wide enough never to wrap; only packing flags.
        if (c.op == OP_RSCALE) x = y;
        if (x.cls == CLS_ORD) begin
          r = pack(x.sign, x.exp + 34'(signed'(c.op == OP_RSCALE ? a : b)), x.man,
                   c.precDst, field);
        end else r = excRes(x.cls, x.sign, c.precDst);
      end
      OP_FIX: begin
        lim = (c.precDst == PREC_Q) ? LIM_Q : (c.precDst == PREC_H) ? LIM_H : LIM_S;
        if (x.cls == CLS_OVF || x.cls == CLS_NAN) r.flags[FL_IOVF] = 1'b1;
        else if (x.cls == CLS_ORD) begin
          t = {8'h0, x.man, 32'h0};
          if (x.exp >= 34'sh17) t = t << 6'(x.exp - 34'sh17);
          else if (x.exp > -34'sh21) t = t >> 6'(34'sh17 - x.exp);
          else t = 64'h1;
          if (x.exp > 34'sh1f) mag = LIM_S + 33'h1;
          else mag = {1'b0, t[63:32]} + {32'h0, rndUp(mode, x.sign, t[32], t[31], |t[30:0])};
          r.flags[FL_IOVF] = mag > (x.sign ? lim : lim - 33'h1);
          r.word = x.sign ? -mag[31:0] : mag[31:0];
        end
      end
      OP_FLOAT: begin
        iv = intOf(b, c.precSrc);
        mag = iv[32] ? 33'(-iv) : 33'(iv);
        lead = '0;
        for (int i = 0; i < 32; i++) begin
          if (mag[i]) lead = 5'(i);
        end
        sh = mag[31:0] << (5'h1f - lead);
        // Only a halfword target can run out of exponent range.
        if (mag != '0) r = pack(iv[32], 34'(lead), sh[31:8], c.precDst, field);
      end
      OP_TRANS: begin
        if (x.cls == CLS_ORD) r = pack(x.sign, x.exp, x.man, c.precDst, field);
        else r = excRes(x.cls, x.sign, c.precDst);
      end
      OP_NEG, OP_ABS: begin
        if (x.cls == CLS_ORD || x.cls == CLS_ZERO) begin
          r.word = (c.precDst == PREC_H) ? {16'h0, b[15:0]} : b;
          if (c.precDst == PREC_H) r.word[15] = (c.op == OP_NEG) & ~b[15] & (x.cls == CLS_ORD);
          else r.word[31] = (c.op == OP_NEG) & ~b[31] & (x.cls == CLS_ORD);
        end else r = excRes(x.cls, (c.op == OP_NEG) & ~x.sign, c.precDst);
      end
      OP_MIN, OP_MAX: begin
        if (x.cls == CLS_NAN || y.cls == CLS_NAN) r = excRes(CLS_NAN, 1'b0, c.precDst);
        else begin
          pickA = isLess(x, y) == (c.op == OP_MIN);
          r = excRes(pickA ? x.cls : y.cls, pickA ? x.sign : y.sign, c.precDst);
          if (r.word == '0) r.word = pickA ? a : b;
        end
      end
      OP_RNDRD: r.word = {29'h0, field};
      default: r = '0;
    endcase
    return r;
  endfunction

  fcs_ctrl_t ctrl;
  fcs_vec_t vecCfg;
  fcs_state_t state;
  fcs_res_t res;
  logic [31:0] opA;
  logic [31:0] opB;
  logic [31:0] result;
  logic [3:0] resPtr;
  logic [3:0] flags;
  logic [2:0] rndField;
  logic [31:0] mem [MEM_DEPTH];
  logic [4:0] vecIdx;
  logic [4:0] elem;
  logic [3:0] firstIdx;
  logic [3:0] secondIdx;
  logic [3:0] dstIdx;
  logic [3:0] dstBase;
  logic [31:0] rdVal;
  logic rdHit;
  logic wrOk;
  logic wrStatus;
  logic goCmd;
  logic goScalar;
  logic goVec;
  logic vecAble;
  logic stepValid;
  logic down;
  logic busy;

  assign busy = state == ST_VEC;
  assign wrOk = psel & penable & pready & pwrite & !busy;
  assign wrStatus = wrOk & (paddr == OFF_STATUS);
  assign goCmd = wrOk & (paddr == OFF_GO) & pwdata[0];
  assign vecAble = ctrl.vec & (ctrl.op inside {OP_FIX, OP_FLOAT, OP_TRANS, OP_NEG, OP_ABS,
                                                OP_MIN, OP_MAX});
  assign goScalar = goCmd & !vecAble;
  assign goVec = goCmd & vecAble & (vecCfg.len != '0);
  assign stepValid = busy;

  // Destination for min/max is the first vector or the pointed-to vector.
  assign dstBase = (ctrl.op inside {OP_MIN, OP_MAX}) && !ctrl.toFirst ? resPtr
                                                                       : vecCfg.firstBase;
  // A destination above the second source is walked downward so that source is not overwritten early.
  assign down = dstBase > vecCfg.secondBase;
  assign elem = down ? vecCfg.len - 5'h1 - vecIdx : vecIdx;
  assign firstIdx = vecCfg.firstBase + elem[3:0];
  assign secondIdx = vecCfg.secondBase + elem[3:0];
  assign dstIdx = dstBase + elem[3:0];

  always_comb begin
    res = execOp(ctrl, stepValid ? mem[firstIdx] : opA, stepValid ? mem[secondIdx] : opB,
                 rndField, stepValid);
  end

  always_comb begin
    rdVal = '0;
    rdHit = 1'b1;
    if (isMemAddr(paddr)) rdVal = mem[paddr[MEM_IDX_HI:MEM_IDX_LO]];
    else begin
      case (paddr)
        OFF_CTRL: rdVal = {19'h0, ctrl};
        OFF_OPA: rdVal = opA;
        OFF_OPB: rdVal = opB;
        OFF_RESULT: rdVal = result;
        OFF_STATUS: begin
          rdVal[ST_BUSY] = busy;
          rdVal[ST_FLAG_LO +: 4] = flags;
          rdVal[ST_RND_LO +: 3] = rndField;
        end
        OFF_RESPTR: rdVal = {28'h0, resPtr};
        OFF_VEC: rdVal = {19'h0, vecCfg};
        OFF_GO: rdVal = '0;
        default: rdHit = 1'b0;
      endcase
    end
  end

  // One wait state: the answer is registered in the first access cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & !pready;
      if (psel & penable & !pready) begin
        prdata <= pwrite ? '0 : rdVal;
        pslverr <= !rdHit;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      vecCfg <= '0;
      resPtr <= '0;
      opA <= '0;
      opB <= '0;
    end else begin
      if (wrOk && paddr == OFF_CTRL) ctrl <= pwdata[$bits(fcs_ctrl_t)-1:0];
      if (wrOk && paddr == OFF_VEC) vecCfg <= pwdata[$bits(fcs_vec_t)-1:0];
      if (wrOk && paddr == OFF_RESPTR) resPtr <= pwdata[3:0];
      if (wrOk && paddr == OFF_OPB) opB <= pwdata;
      if (goScalar && ctrl.op == OP_RNDRD) opA <= res.word;
      else if (wrOk && paddr == OFF_OPA) opA <= pwdata;
    end
  end

  // The rounding write takes only the field's low bits of the first operand.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rndField <= RND_RESET;
    else if (goScalar && ctrl.op == OP_RNDWR) rndField <= opA[2:0];
    else if (wrStatus) rndField <= pwdata[ST_RND_LO +: 3];
  end

  // A flag raised in the same cycle as a status write survives the write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flags <= '0;
    else flags <= (wrStatus ? pwdata[ST_FLAG_LO +: 4] : flags) |
                  ((goScalar | stepValid) ? res.flags : 4'h0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) result <= '0;
    else if (goScalar | stepValid) result <= res.word;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      vecIdx <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          vecIdx <= '0;
          if (goVec) state <= ST_VEC;
        end
        ST_VEC: begin
          vecIdx <= vecIdx + 5'h1;
          if (vecIdx + 5'h1 >= vecCfg.len) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (stepValid) mem[dstIdx] <= res.word;
    else if (wrOk && isMemAddr(paddr)) mem[paddr[MEM_IDX_HI:MEM_IDX_LO]] <= pwdata;
  end

  stickyFlags_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wrStatus |=> (flags & $past(flags)) == $past(flags))
    else $error("real flag cleared without a status write");
  apbWait_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not given after one wait state");
  rndWrite_a: assert property (@(posedge clk) disable iff (!rst_n)
    goScalar && ctrl.op == OP_RNDWR |=> rndField == $past(opA[2:0]))
    else $error("rounding write did not load the field");
  rndRead_a: assert property (@(posedge clk) disable iff (!rst_n)
    goScalar && ctrl.op == OP_RNDRD |=> opA == {29'h0, $past(rndField)})
    else $error("rounding read did not copy the field");
  negOrd_a: assert property (@(posedge clk) disable iff (!rst_n)
    goScalar && ctrl.op == OP_NEG && ctrl.precDst == PREC_S && opB[30:23] != S_EXP_ONES
    && opB[30:23] != 8'h0 |=> result == ($past(opB) ^ {1'b1, 31'h0}))
    else $error("negate of ordinary value wrong");
  fixExc_a: assert property (@(posedge clk) disable iff (!rst_n)
    goScalar && ctrl.op == OP_FIX && ctrl.precSrc == PREC_S && opB[30:23] == S_EXP_ONES
    |=> flags[FL_IOVF])
    else $error("fix of overflow or invalid did not flag");
  floatOvf_a: assert property (@(posedge clk) disable iff (!rst_n)
    goScalar && ctrl.op == OP_FLOAT && ctrl.precDst == PREC_H && ctrl.precSrc == PREC_S
    && opB[31:30] == 2'h1 |=> flags[FL_ROVF])
    else $error("halfword float of large integer did not overflow");
  minNan_a: assert property (@(posedge clk) disable iff (!rst_n)
    goScalar && ctrl.op == OP_MIN && ctrl.precDst == PREC_S && opB == S_NAN
    |=> result == S_NAN && flags[FL_NAN])
    else $error("minimum with invalid operand not invalid");
  scaleZero_a: assert property (@(posedge clk) disable iff (!rst_n)
    goScalar && ctrl.op == OP_SCALE && ctrl.precDst == PREC_S && opB == '0
    && opA[30:23] != S_EXP_ONES && opA[30:23] != 8'h0 |=> result == $past(opA))
    else $error("scale by two to zero changed the value");
  vecStep_a: assert property (@(posedge clk) disable iff (!rst_n)
    busy && vecIdx + 5'h1 < vecCfg.len |=> busy && vecIdx == $past(vecIdx) + 5'h1)
    else $error("vector walk skipped or stopped early");
endmodule // fcs_unit
`default_nettype wire

// *** fcs_pkg.sv ***
// Shared constants and types of the real-number convert, scale and min/max unit.
// Assumes a 32-bit APB master and one clock domain.
package fcs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPA = 8'h04;
  localparam logic [7:0] OFF_OPB = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RESPTR = 8'h14;
  localparam logic [7:0] OFF_VEC = 8'h18;
  localparam logic [7:0] OFF_GO = 8'h1c;
  localparam logic [7:0] OFF_MEM = 8'h40;
  localparam logic [7:0] MEM_MASK = 8'hc3;
  localparam int MEM_IDX_LO = 2;
  localparam int MEM_IDX_HI = 5;
  localparam int MEM_DEPTH = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_FLAG_LO = 1;
  localparam int ST_RND_LO = 8;
  localparam int FL_ROVF = 0;
  localparam int FL_RUNF = 1;
  localparam int FL_NAN = 2;
  localparam int FL_IOVF = 3;
  localparam logic [3:0] OP_RECIP = 4'h0;
  localparam logic [3:0] OP_SCALE = 4'h1;
  localparam logic [3:0] OP_RSCALE = 4'h2;
  localparam logic [3:0] OP_FIX = 4'h3;
  localparam logic [3:0] OP_FLOAT = 4'h4;
  localparam logic [3:0] OP_TRANS = 4'h5;
  localparam logic [3:0] OP_NEG = 4'h6;
  localparam logic [3:0] OP_ABS = 4'h7;
  localparam logic [3:0] OP_MIN = 4'h8;
  localparam logic [3:0] OP_MAX = 4'h9;
  localparam logic [3:0] OP_RNDRD = 4'ha;
  localparam logic [3:0] OP_RNDWR = 4'hb;
  localparam logic [1:0] PREC_Q = 2'h0;
  localparam logic [1:0] PREC_H = 2'h1;
  localparam logic [1:0] PREC_S = 2'h2;
  localparam logic [1:0] PREC_D = 2'h3;
  localparam logic [2:0] RND_FLOOR = 3'h0;
  localparam logic [2:0] RND_TRUNC = 3'h1;
  localparam logic [2:0] RND_HALFUP = 3'h2;
  localparam logic [2:0] RND_STABLE = 3'h3;
  localparam logic [2:0] RND_CEIL = 3'h4;
  localparam logic [2:0] RND_CONFIG = 3'h5;
  localparam logic [2:0] RND_RESET = RND_FLOOR;
  localparam logic signed [33:0] H_BIAS = 34'sh0f;
  localparam logic signed [33:0] S_BIAS = 34'sh7f;
  localparam logic signed [33:0] H_BE_MAX = 34'sh1e;
  localparam logic signed [33:0] S_BE_MAX = 34'shfe;
  localparam logic [4:0] H_EXP_ONES = 5'h1f;
  localparam logic [7:0] S_EXP_ONES = 8'hff;
  localparam logic [32:0] LIM_Q = 33'h80;
  localparam logic [32:0] LIM_H = 33'h8000;
  localparam logic [32:0] LIM_S = 33'h080000000;
  localparam logic [47:0] RECIP_NUM = 48'h800000000000;
  localparam logic [31:0] S_NAN = {1'b0, S_EXP_ONES, 23'h1};
  typedef struct packed {
    logic [1:0] precSrc;
    logic [1:0] precDst;
    logic [2:0] rnd;
    logic toFirst;
    logic vec;
    logic [3:0] op;
  } fcs_ctrl_t;
  typedef struct packed {
    logic [4:0] len;
    logic [3:0] secondBase;
    logic [3:0] firstBase;
  } fcs_vec_t;
  typedef enum logic [2:0] {CLS_ZERO, CLS_ORD, CLS_UNF, CLS_OVF, CLS_NAN} fcs_cls_t;
  typedef struct packed {
    fcs_cls_t cls;
    logic sign;
    logic signed [33:0] exp;
    logic [23:0] man;
  } fcs_real_t;
  typedef struct packed {
    logic [31:0] word;
    logic [3:0] flags;
  } fcs_res_t;
  typedef enum logic {ST_IDLE, ST_VEC} fcs_state_t;
endpackage

// *** fcs_unit_tb.sv ***
// Self-checking bench for the convert, scale and min/max unit.
// Assumes the APB map and real formats of fcs_pkg; drives the ports directly.
`timescale 1ns/10ps
`default_nettype none
module fcs_unit_tb;
  import fcs_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, res, st, rd, seed, v, w;
  logic [31:0] fixPos [6] = '{32'h2, 32'h2, 32'h3, 32'h2, 32'h3, 32'h3};
  logic [31:0] fixNeg [6] = '{32'hfffffffd, 32'hfffffffe, 32'hfffffffe, 32'hfffffffe,
    32'hfffffffe, 32'hfffffffe};
  logic [31:0] q [3];
  int miscompares, num_checks, n;
  fcs_unit fcs_unit_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Random ordinary single real: exponent kept clear of zero and all ones.
  function automatic logic [31:0] rnd_s();
    logic [31:0] r;
    r = xs();
    r[30:23] = 8'(r[30:23] % 8'd254 + 8'd1);
    return r;
  endfunction
  function automatic logic lt(logic [31:0] a, logic [31:0] b);
    if (a[31] != b[31]) return a[31];
    return a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);
  endfunction
  function automatic logic [31:0] cc(logic [3:0] o, logic [2:0] r, logic [1:0] d,
      logic [1:0] s, logic vc);
    fcs_ctrl_t k;
    k = '{precSrc: s, precDst: d, rnd: r, toFirst: 1'b0, vec: vc, op: o};
    return {19'h0, k};
  endfunction
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic er);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      miscompares++;
      give_verdict();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, e);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic op(input logic [31:0] k, input logic [31:0] a, input logic [31:0] b,
      input logic clr, input logic [2:0] fld);
    if (clr) wr(OFF_STATUS, {21'h0, fld, 8'h0});
    wr(OFF_CTRL, k);
    wr(OFF_OPA, a);
    wr(OFF_OPB, b);
    wr(OFF_GO, 32'h1);
    rdr(OFF_RESULT, res);
    rdr(OFF_STATUS, st);
  endtask
  initial begin
    seed = 32'h3;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdr(OFF_STATUS, rd);
    chk(rd, 32'h0);
    rdr(8'h20, rd);
    chk({31'h0, e}, 32'h1);
    rdr(8'h02, rd);
    chk({31'h0, e}, 32'h1);
    op(cc(OP_RNDWR, 3'h0, PREC_S, PREC_S, 1'b0), {29'h0, RND_CEIL}, 32'h0, 1'b0, 3'h0);
    chk({29'h0, st[10:8]}, 32'h4);
    op(cc(OP_RNDRD, 3'h0, PREC_S, PREC_S, 1'b0), 32'h0, 32'h0, 1'b0, 3'h0);
    chk(res, 32'h4);
    op(cc(OP_RECIP, 3'h0, PREC_S, PREC_S, 1'b0), 32'h0, 32'h40000000, 1'b1, 3'h0);
    chk(res, 32'h3f000000);
    op(cc(OP_SCALE, 3'h0, PREC_S, PREC_S, 1'b0), 32'h3f800000, 32'h3, 1'b1, 3'h0);
    chk(res, 32'h41000000);
    op(cc(OP_RSCALE, 3'h0, PREC_S, PREC_S, 1'b0), 32'h3, 32'h3f800000, 1'b1, 3'h0);
    chk(res, 32'h41000000);
    op(cc(OP_SCALE, 3'h0, PREC_S, PREC_S, 1'b0), 32'h7f000000, -32'd250, 1'b1, 3'h0);
    chk(res, 32'h02000000);
    chk({28'h0, st[4:1]}, 32'h0);
    op(cc(OP_SCALE, 3'h0, PREC_S, PREC_S, 1'b0), 32'h3f800000, -32'd200, 1'b1, 3'h0);
    chk({31'h0, st[2]}, 32'h1);
    for (int m = 0; m < 6; m++) begin
      op(cc(OP_FIX, 3'(m), PREC_S, PREC_S, 1'b0), 32'h0, 32'h40200000, 1'b1, RND_CEIL);
      chk(res, fixPos[m]);
      op(cc(OP_FIX, 3'(m), PREC_S, PREC_S, 1'b0), 32'h0, 32'hc0200000, 1'b1, RND_CEIL);
      chk(res, fixNeg[m]);
      chk({31'h0, st[4]}, 32'h0);
    end
    op(cc(OP_FIX, RND_FLOOR, PREC_Q, PREC_S, 1'b0), 32'h0, 32'h43960000, 1'b1, 3'h0);
    chk({31'h0, st[4]}, 32'h1);
    op(cc(OP_FIX, RND_FLOOR, PREC_S, PREC_S, 1'b0), 32'h0, 32'h7f800001, 1'b1, 3'h0);
    chk({31'h0, st[4]}, 32'h1);
    op(cc(OP_FLOAT, 3'h0, PREC_S, PREC_S, 1'b0), 32'h0, 32'h1, 1'b1, 3'h0);
    chk(res, 32'h3f800000);
    op(cc(OP_FLOAT, 3'h0, PREC_H, PREC_S, 1'b0), 32'h0, 32'h40000000, 1'b1, 3'h0);
    chk({31'h0, st[1]}, 32'h1);
    op(cc(OP_FLOAT, 3'h0, PREC_H, PREC_Q, 1'b0), 32'h0, 32'h64, 1'b1, 3'h0);
    chk({res[15:0], 15'h0, st[1]}, {16'h5640, 16'h0});
    op(cc(OP_TRANS, 3'h0, PREC_H, PREC_S, 1'b0), 32'h0, 32'h3f800000, 1'b1, 3'h0);
    chk({16'h0, res[15:0]}, 32'h3c00);
    op(cc(OP_TRANS, 3'h0, PREC_H, PREC_H, 1'b0), 32'h0, 32'h7c01, 1'b1, 3'h0);
    chk({res[15:0], 12'h0, st[4:1]}, {16'h7c01, 16'h4});
    op(cc(OP_ABS, 3'h0, PREC_H, PREC_H, 1'b0), 32'h0, 32'hfc00, 1'b1, 3'h0);
    chk({res[15:0], 12'h0, st[4:1]}, {16'h7c00, 16'h1});
    op(cc(OP_NEG, 3'h0, PREC_S, PREC_S, 1'b0), 32'h0, 32'h3f800000, 1'b0, 3'h0);
    chk(res, 32'hbf800000);
    chk({28'h0, st[4:1]}, 32'h1);
    wr(OFF_STATUS, 32'h0);
    rdr(OFF_STATUS, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 20; i++) begin
      v = rnd_s();
      w = rnd_s();
      op(cc(OP_MIN, 3'h0, PREC_S, PREC_S, 1'b0), v, w, 1'b1, 3'h0);
      chk(res, lt(v, w) ? v : w);
      op(cc(OP_MAX, 3'h0, PREC_S, PREC_S, 1'b0), v, w, 1'b1, 3'h0);
      chk(res, lt(v, w) ? w : v);
      op(cc(OP_NEG, 3'h0, PREC_S, PREC_S, 1'b0), 32'h0, v, 1'b1, 3'h0);
      chk(res, v ^ 32'h80000000);
      chk({28'h0, st[4:1]}, 32'h0);
      op(cc(OP_SCALE, 3'h0, PREC_S, PREC_S, 1'b0), v, 32'h0, 1'b1, 3'h0);
      chk(res, v);
    end
    op(cc(OP_MAX, 3'h0, PREC_S, PREC_S, 1'b0), 32'h7f800001, 32'hff800000, 1'b1, 3'h0);
    chk(res, S_NAN);
    chk({28'h0, st[4:1]}, 32'h4);
    op(cc(OP_MIN, 3'h0, PREC_S, PREC_S, 1'b0), 32'hff800000, S_NAN, 1'b1, 3'h0);
    chk(res, S_NAN);
    for (int i = 0; i < 3; i++) begin
      q[i] = rnd_s();
      wr(8'(OFF_MEM + 4 * (i + 4)), q[i]);
    end
    wr(OFF_CTRL, cc(OP_NEG, 3'h0, PREC_S, PREC_S, 1'b1));
    // Second pass puts the target one word above an equal-precision source.
    for (int p = 0; p < 2; p++) begin
      wr(OFF_VEC, {19'h0, 5'd3, 4'd4, p ? 4'd5 : 4'd0});
      wr(OFF_GO, 32'h1);
      n = 0;
      do begin
        rdr(OFF_STATUS, rd);
        n++;
      end while (rd[ST_BUSY] !== 1'b0 && n < 20);
      chk({31'h0, rd[ST_BUSY]}, 32'h0);
      for (int i = 0; i < 3; i++) begin
        rdr(8'(OFF_MEM + 4 * (i + 5 * p)), rd);
        chk(rd, q[i] ^ 32'h80000000);
        if (p == 0) begin
          rdr(8'(OFF_MEM + 4 * (i + 4)), rd);
          chk(rd, q[i]);
        end
      end
    end
    give_verdict();
  end
endmodule // fcs_unit_tb
`default_nettype wire
